//--- core/sebr_defines.vh
`ifndef SEBR_DEFINES_VH
`define SEBR_DEFINES_VH

// register indices; byte address of the low word is four times the index
`define SEBR_IDX_SAMPLING_CONTROL 12'h3f1
`define SEBR_IDX_MATRIX_VERTICAL 12'h3f2
`define SEBR_IDX_BANK0_CONTROL 12'h400
`define SEBR_IDX_BANK0_STATUS 12'h401
`define SEBR_IDX_BANK0_ADDRESS 12'h402
`define SEBR_IDX_BANK0_EXTRA_INFO 12'h403
`define SEBR_IDX_BANK1_CONTROL 12'h404
`define SEBR_IDX_BANK1_STATUS 12'h405
`define SEBR_IDX_EVENT_STATUS 12'h410
`define SEBR_IDX_EVENT_MASK 12'h411

// address bit that selects the upper 32 bits of a 64-bit register
`define SEBR_HI_SEL_BIT 14

// slots of the storage array
`define SEBR_SLOT_SAMPLING 4'h0
`define SEBR_SLOT_MATRIX 4'h1
`define SEBR_SLOT_CTL0 4'h2
`define SEBR_SLOT_STAT0 4'h3
`define SEBR_SLOT_ADDR0 4'h4
`define SEBR_SLOT_MISC0 4'h5
`define SEBR_SLOT_CTL1 4'h6
`define SEBR_SLOT_STAT1 4'h7
`define SEBR_SLOT_EVSTAT 4'h8
`define SEBR_SLOT_EVMASK 4'h9
`define SEBR_SLOT_NONE 4'hf

// sampling control fields
`define SEBR_SAMP_EVENT_MASK 64'h0000_0000_0000_1fff
`define SEBR_BIT_REPLAY_TAG 24
`define SEBR_BIT_THIS_THREAD 25
`define SEBR_BIT_SIBLING_THREAD 26
`define SEBR_SAMP_RESET 64'h0000_0000_0000_0000

// bank status flags
`define SEBR_BIT_ADDRESS_VALID 58
`define SEBR_BIT_EXTRA_INFO_VALID 59

// event status bits
`define SEBR_EV_BANK0_LOGGED 0
`define SEBR_EV_BANK1_LOGGED 1
`define SEBR_EV_GP_FAULT 2
`define SEBR_EV_WIDTH 3

`define SEBR_RESP_OKAY 2'b00
`define SEBR_RESP_SLVERR 2'b10
`define SEBR_RESP_DECERR 2'b11

`endif

//--- core/sebr_reg64.v
`timescale 1ns/1ps
`default_nettype none
module sebr_reg64 #(
  parameter [63:0] WMASK = 64'hffff_ffff_ffff_ffff
) (
  input wire core_clk,
  input wire rst_n,
  input wire wr_lo,
  input wire wr_hi,
  input wire [3:0] wstrb,
  input wire [31:0] wdata,
  input wire hw_load,
  input wire [63:0] hw_data,
  output reg [63:0] q
);
  reg [63:0] next_q;
  integer i;

  always @* begin
    next_q = q;
    for (i = 0; i < 4; i = i + 1) begin
      if (wr_lo && wstrb[i]) begin
        next_q[8*i +: 8] = wdata[8*i +: 8];
      end
      if (wr_hi && wstrb[i]) begin
        next_q[32+8*i +: 8] = wdata[8*i +: 8];
      end
    end
    // hardware logging wins over a software write in the same cycle
    if (hw_load) begin
      next_q = hw_data;
    end
    next_q = next_q & WMASK;
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 64'h0000_0000_0000_0000;
    end else begin
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

//--- core/sebr_bank.v
// How it works
// (RQ1) bit 25 enables precise sampling for this thread; cleared at reset
// (RQ2) bit 26 enables precise sampling for the sibling thread; cleared at reset
// (RQ3) without sibling threads bit 26 is reserved and bit 25 is the only enable
// (RQ4) bank 0 address holds no valid address while its address-valid flag is clear
// (RQ5) access to an unimplemented address or extra-info register faults, never completes; here the access ends with a SLVERR response and a gp_fault pulse
// (RQ6) bank 0 extra info carries nothing while its extra-info-valid flag is clear
// (RQ7) bit 24 turns on replay tagging of micro-operations
// (RQ8) sampling control bits 63 to 27 read zero and ignore writes
//
// Decided for this implementation: register access over AXI4-Lite.
`include "sebr_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module sebr_bank #(
  parameter MULTI_THREAD = 1,
  parameter BANK0_ADDR_IMPL = 1,
  parameter BANK0_MISC_IMPL = 1
) (
  input wire core_clk,
  input wire rst_n,
  input wire [15:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [15:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire bank0_log,
  input wire [63:0] bank0_log_status,
  input wire [63:0] bank0_log_address,
  input wire [63:0] bank0_log_extra_info,
  input wire bank1_log,
  input wire [63:0] bank1_log_status,
  output wire sample_enable_this_thread,
  output wire sample_enable_sibling_thread,
  output wire replay_tag_enable,
  output wire bank0_address_valid,
  output wire bank0_extra_info_valid,
  output reg gp_fault,
  output wire irq
);
  // writable bits of sampling control; reserved bits stay zero
  localparam [63:0] SAMP_WMASK = `SEBR_SAMP_EVENT_MASK
    | (64'h1 << `SEBR_BIT_REPLAY_TAG) | (64'h1 << `SEBR_BIT_THIS_THREAD)
    | ((MULTI_THREAD != 0) ? (64'h1 << `SEBR_BIT_SIBLING_THREAD) : 64'h0); // RQ3 RQ8

  reg rst_meta;
  reg rst_sync;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  function [3:0] slot_of;
    input [15:0] addr;
    reg [11:0] idx;
    begin
      idx = addr[13:2];
      if (idx == `SEBR_IDX_SAMPLING_CONTROL) begin
        slot_of = `SEBR_SLOT_SAMPLING;
      end else if (idx == `SEBR_IDX_MATRIX_VERTICAL) begin
        slot_of = `SEBR_SLOT_MATRIX;
      end else if (idx == `SEBR_IDX_BANK0_CONTROL) begin
        slot_of = `SEBR_SLOT_CTL0;
      end else if (idx == `SEBR_IDX_BANK0_STATUS) begin
        slot_of = `SEBR_SLOT_STAT0;
      end else if (idx == `SEBR_IDX_BANK0_ADDRESS) begin
        slot_of = `SEBR_SLOT_ADDR0;
      end else if (idx == `SEBR_IDX_BANK0_EXTRA_INFO) begin
        slot_of = `SEBR_SLOT_MISC0;
      end else if (idx == `SEBR_IDX_BANK1_CONTROL) begin
        slot_of = `SEBR_SLOT_CTL1;
      end else if (idx == `SEBR_IDX_BANK1_STATUS) begin
        slot_of = `SEBR_SLOT_STAT1;
      end else if (idx == `SEBR_IDX_EVENT_STATUS) begin
        slot_of = `SEBR_SLOT_EVSTAT;
      end else if (idx == `SEBR_IDX_EVENT_MASK) begin
        slot_of = `SEBR_SLOT_EVMASK;
      end else begin
        slot_of = `SEBR_SLOT_NONE;
      end
    end
  endfunction

  // an unimplemented address or extra-info register behaves as a faulting slot
  function faults;
    input [3:0] slot;
    begin
      faults = ((slot == `SEBR_SLOT_ADDR0) && (BANK0_ADDR_IMPL == 0))
        || ((slot == `SEBR_SLOT_MISC0) && (BANK0_MISC_IMPL == 0)); // RQ5
    end
  endfunction

  // response code shared by the write and read channels
  function [1:0] resp_of;
    input [3:0] slot;
    begin
      if (faults(slot)) begin
        resp_of = `SEBR_RESP_SLVERR; // RQ5
      end else if (slot == `SEBR_SLOT_NONE) begin
        resp_of = `SEBR_RESP_DECERR;
      end else begin
        resp_of = `SEBR_RESP_OKAY;
      end
    end
  endfunction

  // write channel: address and data are held independently, then applied together
  reg aw_held;
  reg w_held;
  reg [15:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  wire wr_go = aw_held && w_held && !s_axi_bvalid;
  wire [3:0] wr_slot = slot_of(aw_addr);
  wire wr_hi = aw_addr[`SEBR_HI_SEL_BIT];
  wire wr_fault = faults(wr_slot);
  wire wr_ok = wr_go && !wr_fault && (wr_slot != `SEBR_SLOT_NONE);

  always @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 16'h0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SEBR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= resp_of(wr_slot); // RQ5
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // storage for the eight 64-bit registers
  wire [63:0] reg_q [0:7];
  wire [7:0] hw_load;
  wire [63:0] hw_data [0:7];
  assign hw_load = {bank1_log, 1'b0, bank0_log, bank0_log, bank0_log, 3'b000};
  assign hw_data[0] = 64'h0;
  assign hw_data[1] = 64'h0;
  assign hw_data[2] = 64'h0;
  assign hw_data[3] = bank0_log_status;
  assign hw_data[4] = bank0_log_address;
  assign hw_data[5] = bank0_log_extra_info;
  assign hw_data[6] = 64'h0;
  assign hw_data[7] = bank1_log_status;

  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_store
      wire sel = wr_ok && (wr_slot == k);
      sebr_reg64 #(
        .WMASK((k == 0) ? SAMP_WMASK : 64'hffff_ffff_ffff_ffff)
      ) u_reg (
        .core_clk(core_clk),
        .rst_n(rst_sync),
        .wr_lo(sel && !wr_hi),
        .wr_hi(sel && wr_hi),
        .wstrb(w_strb),
        .wdata(w_data),
        .hw_load(hw_load[k]),
        .hw_data(hw_data[k]),
        .q(reg_q[k])
      );
    end
  endgenerate

  wire [63:0] samp = reg_q[0];
  wire [63:0] stat0 = reg_q[3];
  assign sample_enable_this_thread = samp[`SEBR_BIT_THIS_THREAD]; // RQ1 RQ3
  assign sample_enable_sibling_thread = samp[`SEBR_BIT_SIBLING_THREAD]; // RQ2
  assign replay_tag_enable = samp[`SEBR_BIT_REPLAY_TAG]; // RQ7
  assign bank0_address_valid = stat0[`SEBR_BIT_ADDRESS_VALID]; // RQ4
  assign bank0_extra_info_valid = stat0[`SEBR_BIT_EXTRA_INFO_VALID]; // RQ6

  // event bits: set wins over a write-one-to-clear in the same cycle
  reg [`SEBR_EV_WIDTH-1:0] ev_status;
  reg [`SEBR_EV_WIDTH-1:0] ev_mask;
  reg [`SEBR_EV_WIDTH-1:0] next_ev_status;
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire [3:0] rd_slot = slot_of(s_axi_araddr);
  wire rd_fault = faults(rd_slot);
  wire [`SEBR_EV_WIDTH-1:0] ev_set = {(wr_go && wr_fault) || (rd_take && rd_fault),
                                      bank1_log, bank0_log};
  wire ev_lo_wr = wr_go && !wr_hi && w_strb[0];

  always @* begin
    next_ev_status = ev_status;
    if (ev_lo_wr && (wr_slot == `SEBR_SLOT_EVSTAT)) begin
      next_ev_status = ev_status & ~w_data[`SEBR_EV_WIDTH-1:0];
    end
    next_ev_status = next_ev_status | ev_set;
  end

  always @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      ev_status <= {`SEBR_EV_WIDTH{1'b0}};
      ev_mask <= {`SEBR_EV_WIDTH{1'b0}};
      gp_fault <= 1'b0;
    end else begin
      ev_status <= next_ev_status;
      if (ev_lo_wr && (wr_slot == `SEBR_SLOT_EVMASK)) begin
        ev_mask <= w_data[`SEBR_EV_WIDTH-1:0];
      end
      gp_fault <= ev_set[`SEBR_EV_GP_FAULT]; // RQ5
    end
  end
  assign irq = |(ev_status & ev_mask);

  // read channel: one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;
  reg [63:0] rd_word;
  always @* begin
    rd_word = 64'h0;
    if (rd_slot == `SEBR_SLOT_EVSTAT) begin
      rd_word[`SEBR_EV_WIDTH-1:0] = ev_status;
    end else if (rd_slot == `SEBR_SLOT_EVMASK) begin
      rd_word[`SEBR_EV_WIDTH-1:0] = ev_mask;
    end else if ((rd_slot != `SEBR_SLOT_NONE) && !rd_fault) begin
      rd_word = reg_q[rd_slot[2:0]];
    end
  end

  always @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SEBR_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= s_axi_araddr[`SEBR_HI_SEL_BIT] ? rd_word[63:32] : rd_word[31:0];
      s_axi_rresp <= resp_of(rd_slot); // RQ5
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- verification/sebr_bank_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sebr_bank_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic bank0_log,
  input wire logic sample_enable_this_thread,
  input wire logic sample_enable_sibling_thread,
  input wire logic replay_tag_enable,
  input wire logic bank0_address_valid,
  input wire logic bank0_extra_info_valid,
  input wire logic gp_fault
);
  logic [15:0] ra;
  wire logic [2:0] en;
  wire logic rs;
  assign en = {sample_enable_sibling_thread, sample_enable_this_thread, replay_tag_enable};
  assign rs = s_axi_rvalid;
  // address of the read in flight; arready stays low while rvalid is up
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) ra <= '0;
    else if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_samp_bits: assert property (
    rs && ra == 16'h0fc4 |-> s_axi_rdata[26:24] == en) else $error("enable pins differ");
  chk_rsv_low: assert property (
    rs && ra == 16'h0fc4 |-> s_axi_rdata[31:27] == 0) else $error("reserved bits set");
  chk_rsv_high: assert property (
    rs && ra == 16'h4fc4 |-> s_axi_rdata == 0) else $error("reserved word set");
  chk_flags_read: assert property (
    rs && ra == 16'h5004 |-> s_axi_rdata[27:26] == {bank0_extra_info_valid, bank0_address_valid})
    else $error("valid flag pins differ");
  chk_extra_fault: assert property (
    rs && (ra | 16'h4000) == 16'h500c |-> s_axi_rresp == 2'b10 && s_axi_rdata == 0)
    else $error("absent register answered");
  chk_fault_pulse: assert property ($rose(gp_fault) |=> !gp_fault)
    else $error("fault not a pulse");
  chk_fault_follow: assert property (
    $rose(rs) && s_axi_rresp == 2'b10 |-> ##[0:1] gp_fault) else $error("no fault pulse");
  chk_enable_src: assert property ($changed(en) |-> $rose(s_axi_bvalid))
    else $error("enable changed without write");
  chk_flag_src: assert property (
    $changed(bank0_address_valid) |-> $past(bank0_log) || $rose(s_axi_bvalid))
    else $error("flag changed without cause");
  chk_reset_off: assert property ($rose(rst_n) |-> en == 0)
    else $error("enables set after reset");
  cover property ($rose(gp_fault));
  cover property (rs && ra == 16'h0fc4);
  cover property ($rose(bank0_address_valid));
endmodule
`default_nettype wire

//--- verification/sebr_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sebr_bank_tb;
  logic core_clk, rst_n, bank0_log, bank1_log, gp_fault, irq;
  logic [15:0] s_axi_awaddr, s_axi_araddr, a;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [63:0] bank0_log_status, bank0_log_address, bank0_log_extra_info, bank1_log_status;
  logic sample_enable_this_thread, sample_enable_sibling_thread, replay_tag_enable;
  logic bank0_address_valid, bank0_extra_info_valid;
  logic st_this, st_sib;
  logic [1:0] st_rresp, st_rsp;
  logic [31:0] st_rdata, st_d;
  logic [31:0] mdl [int];
  logic [15:0] adr [6] = '{16'h0fc8, 16'h1000, 16'h1004, 16'h1008, 16'h1010, 16'h1014};
  int n_fail, n_compared, seed;
  // extra info left out so its fault path can be reached
  sebr_bank #(.BANK0_MISC_IMPL(0)) u_dut (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bank0_log, .bank0_log_status,
    .bank0_log_address, .bank0_log_extra_info, .bank1_log, .bank1_log_status,
    .sample_enable_this_thread, .sample_enable_sibling_thread, .replay_tag_enable,
    .bank0_address_valid, .bank0_extra_info_valid, .gp_fault, .irq);
  // single-thread variant without an address register follows the same bus traffic
  sebr_bank #(.MULTI_THREAD(0), .BANK0_ADDR_IMPL(0), .BANK0_MISC_IMPL(0)) u_single (.core_clk,
    .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(st_rdata),
    .s_axi_rresp(st_rresp), .s_axi_rvalid(), .s_axi_rready, .bank0_log, .bank0_log_status,
    .bank0_log_address, .bank0_log_extra_info, .bank1_log, .bank1_log_status,
    .sample_enable_this_thread(st_this), .sample_enable_sibling_thread(st_sib),
    .replay_tag_enable(), .bank0_address_valid(), .bank0_extra_info_valid(), .gp_fault(),
    .irq());
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  task conclude;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string n, input logic [63:0] s, input logic [63:0] e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [15:0] ad, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task rd(input logic [15:0] ad);
    @(posedge core_clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
    rsp = s_axi_rresp;
    st_d = st_rdata;
    st_rsp = st_rresp;
    s_axi_rready <= 0;
  endtask
  task rdc(input logic [15:0] ad, input logic [31:0] e, input logic [1:0] er);
    rd(ad);
    chk("rdata", rd_d, e);
    chk("rresp", rsp, er);
  endtask
  initial begin
    seed = 37699;
    n_fail = 0;
    n_compared = 0;
    rst_n = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, bank0_log, bank1_log} = '0;
    {bank0_log_status, bank0_log_address, bank0_log_extra_info, bank1_log_status} = '0;
    s_axi_wstrb = 4'hf;
    repeat (2) @(posedge core_clk);
    rst_n <= 1;
    repeat (3) @(posedge core_clk);
    rdc(16'h0fc4, 0, 0);
    rdc(16'h4fc4, 0, 0);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 32'hffffffff : $random(seed);
      wr(16'h0fc4, v);
      wr(16'h4fc4, ~v);
      rdc(16'h0fc4, v & 32'h07001fff, 0);
      chk("single control", st_d, v & 32'h03001fff);
      chk("single enables", {st_sib, st_this}, {1'b0, v[25]});
      rdc(16'h4fc4, 0, 0);
      chk("enables", {sample_enable_sibling_thread, sample_enable_this_thread,
        replay_tag_enable}, v[26:24]);
    end
    // fill every word before reading any, so aliasing shows up
    for (int i = 0; i < 12; i++) begin
      a = adr[i % 6] | (i >= 6 ? 16'h4000 : 16'h0000);
      v = $random(seed);
      wr(a, v);
      mdl[a] = v;
    end
    foreach (mdl[k]) rdc(k[15:0], mdl[k], 2'b00);
    wr(16'h100c, v);
    chk("bresp", rsp, 2'b10);
    rdc(16'h500c, 0, 2'b10);
    wr(16'h0ff0, v);
    chk("bresp", rsp, 2'b11);
    v = $random(seed);
    @(posedge core_clk);
    bank0_log <= 1;
    bank1_log <= 1;
    bank0_log_status <= {32'h04000000, v};
    bank0_log_address <= {~v, v};
    bank1_log_status <= {v, ~v};
    @(posedge core_clk);
    bank0_log <= 0;
    bank1_log <= 0;
    @(posedge core_clk);
    chk("valid flags", {bank0_extra_info_valid, bank0_address_valid}, 2'b01);
    rdc(16'h5004, 32'h04000000, 0);
    rdc(16'h1008, v, 0);
    chk("single absent address", {st_rsp, st_d}, {2'b10, 32'h0000_0000});
    rdc(16'h1014, ~v, 0);
    rdc(16'h1040, 32'h7, 0);
    wr(16'h1044, 0);
    chk("irq", irq, 0);
    wr(16'h1044, 1);
    chk("irq", irq, 1);
    wr(16'h1040, 7);
    chk("irq", irq, 0);
    rdc(16'h1040, 0, 0);
    conclude;
  end
  initial begin
    #100000;
    n_fail++;
    conclude;
  end
endmodule
bind sebr_bank sebr_bank_chk u_chk (.core_clk, .rst_n, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_bvalid, .bank0_log,
  .sample_enable_this_thread, .sample_enable_sibling_thread, .replay_tag_enable,
  .bank0_address_valid, .bank0_extra_info_valid, .gp_fault);
`default_nettype wire
